/* verilog/emb_pkg.sv */
// emb_pkg: constants shared by the external memory bus block
// assumes: one 25 MHz core clock, registers reached over wishbone
package emb_pkg;
  // ---------------------------------------------------------------
  // bus cycle timing
  // ---------------------------------------------------------------
  localparam int           MC_CLKS  = 4;   // clocks per machine cycle
  localparam int           ALE_CLKS = 2;   // ale high part of address mc
  localparam logic [3:0]   MC_MIN   = 4'h2; // shortest data move
  localparam logic [3:0]   MC_MAX   = 4'h9; // longest data move
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0]   OFF_CTRL   = 5'h00; // stretch, enables
  localparam logic [4:0]   OFF_PTR0   = 5'h04; // standard pointer
  localparam logic [4:0]   OFF_P1LOW  = 5'h08; // second_pointer_low
  localparam logic [4:0]   OFF_P1HIGH = 5'h0c; // second_pointer_high
  localparam logic [4:0]   OFF_CMD    = 5'h10; // opcode and data
  localparam logic [4:0]   OFF_STAT   = 5'h14; // busy and read data
  localparam logic [4:0]   OFF_LATCH  = 5'h18; // general port latches
  // ---------------------------------------------------------------
  // control field positions and reset values
  // ---------------------------------------------------------------
  localparam int           CTL_STR   = 0;  // stretch, bits 2:0
  localparam int           CTL_XRAM  = 3;  // onchip_xram_enable
  localparam int           CTL_WAIT  = 4;  // wait pin function on
  localparam int           CTL_DPSEL = 5;  // pointer selector
  localparam logic [5:0]   CTRL_RST  = 6'h00;
  localparam logic [8:0]   LATCH_RST = 9'h1ff;
  localparam logic [15:0]  PTR_RST   = 16'h0000;
  // ---------------------------------------------------------------
  // command opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0]   OP_XRD  = 8'he0; // external_data_move read
  localparam logic [7:0]   OP_XWR  = 8'hf0; // external_data_move write
  localparam logic [7:0]   OP_CODE = 8'h93; // code_table_read
  localparam logic [7:0]   OP_INC  = 8'ha3; // pointer increment
  localparam logic [7:0]   OP_DEC  = 8'ha5; // pointer_decrement_op
  // ---------------------------------------------------------------
  // on-chip data ram
  // ---------------------------------------------------------------
  localparam int           XRAM_AW  = 10;
  localparam logic [15:0]  XRAM_TOP = 16'h03ff;
  // ---------------------------------------------------------------
  // access sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10,
    ST_IRAM = 2'b11
  } emb_state_e;
endpackage : emb_pkg

/* verilog/emb_sync2.sv */
// emb_sync2: two flip-flop synchroniser for pin inputs
// assumes: inputs are asynchronous levels, reset value all ones
`timescale 1ns/1ns
module emb_sync2 #(
  parameter int W = 9
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta; // first stage, read only by second stage

  // ---------------------------------------------------------------
  // two stages, pulled-up idle level after reset
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : emb_sync2

/* verilog/emb_xram.sv */
// emb_xram: on-chip data ram, registered read port
// assumes: single clock, one access per cycle
`timescale 1ns/1ns
module emb_xram #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  input  wire logic          mclk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1]; // contents undefined at power up

  // ---------------------------------------------------------------
  // read before write, read data valid one clock later
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
    rdata_o <= mem[addr_i];
  end
endmodule : emb_xram

/* verilog/emb_top.sv */
// emb_top: external program/data memory bus with on-chip data ram
// assumes: wishbone classic master, pins resolved by the testbench
//
// How it works
// - low port carries address, then data
// - low port push-pull on bus, else open-drain
// - high port drives upper address during external access
// - write and read strobes for data moves
// - data move stretch two to nine cycles
// - machine cycle is four clocks
// - 1KB on-chip ram at 0000H-03FFH
// - wait pin extends access when enabled
// - second 16-bit pointer, low and high bytes
// - opcode A5H decrements active pointer
// - ale lets outside latch capture address
// - fetch strobe gates code reads
// - ram enable routes low range inside
// - addresses above 03FFH always go outside
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ns
module emb_top (
  input  wire logic             mclk_i,
  input  wire logic             reset_n_i,
  // wishbone classic slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [4:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // memory bus pins
  input  wire logic [7:0]       low_addr_data_port_i,
  output logic      [7:0]       low_addr_data_port_o,
  output logic      [7:0]       low_addr_data_port_oe_n_o,
  output logic      [7:0]       high_address_port_o,
  output logic                  high_address_port_oe_n_o,
  output logic                  ale_o,
  output logic                  program_fetch_strobe_n_o,
  output logic                  ext_write_strobe_pin_n_o,
  output logic                  ext_read_strobe_pin_n_o,
  input  wire logic             wait_capable_pin_n_i,
  output logic                  wait_capable_pin_o,
  output logic                  wait_capable_pin_oe_n_o
);
  import emb_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  emb_state_e  state;        // access sequencer
  logic [5:0]  ctrl;         // control register
  logic [15:0] dptr0;        // standard data_pointer
  logic [7:0]  p1_low;       // second_pointer_low
  logic [7:0]  p1_high;      // second_pointer_high
  logic [8:0]  latch;        // port latches, bit 8 wait pin
  logic [7:0]  op;           // opcode of running access
  logic [15:0] acc_addr;     // address of running access
  logic [7:0]  wdata;        // write data of running access
  logic [7:0]  rdata;        // last read byte
  logic [5:0]  cnt;          // clock within access
  logic [5:0]  tot;          // clocks in access
  logic [8:0]  pins_s;       // synchronised pin inputs
  logic [7:0]  ram_q;        // on-chip ram read data
  logic        wb_take;      // request taken this edge
  logic        cmd_go;       // command accepted
  logic        hold;         // wait pin stretching access
  logic [15:0] dp;           // active pointer
  logic [7:0]  cmd_op;       // opcode in command write
  logic        ram_we;       // on-chip ram write

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // low range goes inside only while the ram is enabled
  function automatic logic is_internal(input logic [15:0] a,
                                       input logic        en);
    is_internal = en && (a <= XRAM_TOP);
  endfunction : is_internal

  assign wb_take = cyc_i && stb_i && !ack_o;
  assign cmd_op  = dat_i[7:0];
  assign cmd_go  = wb_take && we_i && (adr_i == OFF_CMD) && sel_i[0]
                   && (state == ST_IDLE);
  assign dp      = ctrl[CTL_DPSEL] ? {p1_high, p1_low} : dptr0;
  assign hold    = ctrl[CTL_WAIT] && !pins_s[8]
                   && (cnt == tot - 6'd2);
  assign ram_we  = (state == ST_IRAM) && (cnt == 6'd0)
                   && (op == OP_XWR);

  // ---------------------------------------------------------------
  // pin inputs through two flops
  // ---------------------------------------------------------------
  emb_sync2 #(.W(9)) u_sync (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .async_i   ({wait_capable_pin_n_i, low_addr_data_port_i}),
    .sync_o    (pins_s)
  );

  // ---------------------------------------------------------------
  // on-chip data ram
  // ---------------------------------------------------------------
  emb_xram #(.AW(XRAM_AW), .DW(8)) u_xram (
    .mclk_i  (mclk_i),
    .we_i    (ram_we),
    .addr_i  (acc_addr[XRAM_AW-1:0]),
    .wdata_i (wdata),
    .rdata_o (ram_q)
  );

  // ---------------------------------------------------------------
  // wishbone answer: ack one cycle after take, then drop
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_take;
      if (wb_take && !we_i) begin
        // unmapped offsets read as zero
        if (adr_i == OFF_CTRL) begin
          dat_o <= {26'h0, ctrl};
        end else if (adr_i == OFF_PTR0) begin
          dat_o <= {16'h0, dptr0};
        end else if (adr_i == OFF_P1LOW) begin
          dat_o <= {24'h0, p1_low};
        end else if (adr_i == OFF_P1HIGH) begin
          dat_o <= {24'h0, p1_high};
        end else if (adr_i == OFF_STAT) begin
          dat_o <= {16'h0, rdata, 7'h0, state != ST_IDLE};
        end else if (adr_i == OFF_LATCH) begin
          dat_o <= {23'h0, latch};
        end else begin
          dat_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // control and latch registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ctrl  <= CTRL_RST;
      latch <= LATCH_RST;
    end else if (wb_take && we_i && sel_i[0]) begin
      if (adr_i == OFF_CTRL) begin
        ctrl <= dat_i[5:0];
      end else if (adr_i == OFF_LATCH) begin
        latch[7:0] <= dat_i[7:0];
      end
      if (adr_i == OFF_LATCH && sel_i[1]) begin
        latch[8] <= dat_i[8];
      end
    end
  end

  // ---------------------------------------------------------------
  // data pointers: software writes, increment and decrement
  // ---------------------------------------------------------------
  // commands only run while idle, so they never meet a pointer write
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      dptr0   <= PTR_RST;
      p1_low  <= PTR_RST[7:0];
      p1_high <= PTR_RST[15:8];
    end else if (cmd_go && (cmd_op == OP_INC || cmd_op == OP_DEC)) begin
      if (ctrl[CTL_DPSEL]) begin
        {p1_high, p1_low} <= (cmd_op == OP_DEC) ? dp - 16'h0001
                                                : dp + 16'h0001;
      end else begin
        dptr0 <= (cmd_op == OP_DEC) ? dp - 16'h0001
                                    : dp + 16'h0001;
      end
    end else if (wb_take && we_i) begin
      if (adr_i == OFF_PTR0) begin
        if (sel_i[0]) dptr0[7:0]  <= dat_i[7:0];
        if (sel_i[1]) dptr0[15:8] <= dat_i[15:8];
      end else if (adr_i == OFF_P1LOW && sel_i[0]) begin
        p1_low <= dat_i[7:0];
      end else if (adr_i == OFF_P1HIGH && sel_i[0]) begin
        p1_high <= dat_i[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state    <= ST_IDLE;
      cnt      <= 6'd0;
      tot      <= 6'd0;
      op       <= 8'h00;
      acc_addr <= 16'h0000;
      wdata    <= 8'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 6'd0;
          if (cmd_go) begin
            op       <= cmd_op;
            acc_addr <= dp;
            wdata    <= dat_i[15:8];
            if (cmd_op == OP_XRD || cmd_op == OP_XWR) begin
              // stretch field 0..7 means 2..9 machine cycles
              tot <= {({1'b0, ctrl[2:0]} + MC_MIN), 2'b00};
              if (is_internal(dp, ctrl[CTL_XRAM])) begin
                state <= ST_IRAM;
              end else begin
                state <= ST_ADDR;
              end
            end else if (cmd_op == OP_CODE) begin
              tot   <= {MC_MIN, 2'b00};
              state <= ST_ADDR;
            end
          end
        end
        ST_ADDR: begin
          cnt <= cnt + 6'd1;
          if (cnt == 6'(MC_CLKS - 1)) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          // wait pin freezes the count on the last strobe clock
          if (!hold) begin
            cnt <= cnt + 6'd1;
          end
          if (cnt == tot - 6'd1) begin
            state <= ST_IDLE;
          end
        end
        ST_IRAM: begin
          cnt <= cnt + 6'd1;
          if (cnt == 6'd1) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data capture
  // ---------------------------------------------------------------
  // synced data shows the pin as it stood two clocks before, and the
  // strobe pin lags the state by one; only the last data clock sees
  // the pin inside the strobe at the shortest stretch
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata <= 8'h00;
    end else if (state == ST_DATA && op != OP_XWR
                 && cnt == tot - 6'd1) begin
      rdata <= pins_s[7:0];
    end else if (state == ST_IRAM && cnt == 6'd1 && op == OP_XRD) begin
      rdata <= ram_q;
    end
  end

  // ---------------------------------------------------------------
  // bus pins, registered
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      low_addr_data_port_o      <= 8'h00;
      low_addr_data_port_oe_n_o <= 8'hff;
      high_address_port_o       <= 8'h00;
      high_address_port_oe_n_o  <= 1'b1;
      ale_o                     <= 1'b0;
      program_fetch_strobe_n_o  <= 1'b1;
      ext_write_strobe_pin_n_o  <= 1'b1;
      ext_read_strobe_pin_n_o   <= 1'b1;
    end else begin
      ale_o <= (state == ST_ADDR) && (cnt < 6'(ALE_CLKS));
      high_address_port_o      <= acc_addr[15:8];
      high_address_port_oe_n_o <= !(state == ST_ADDR
                                    || state == ST_DATA);
      if (state == ST_ADDR) begin
        low_addr_data_port_o      <= acc_addr[7:0];
        low_addr_data_port_oe_n_o <= 8'h00;
      end else if (state == ST_DATA && op == OP_XWR) begin
        low_addr_data_port_o      <= wdata;
        low_addr_data_port_oe_n_o <= 8'h00;
      end else if (state == ST_DATA) begin
        low_addr_data_port_o      <= 8'h00;
        low_addr_data_port_oe_n_o <= 8'hff;
      end else begin
        // open drain: pull low only where the latch holds zero
        low_addr_data_port_o      <= 8'h00;
        low_addr_data_port_oe_n_o <= latch[7:0];
      end
      // strobes low from data phase start to one clock before end
      program_fetch_strobe_n_o <= !(state == ST_DATA && op == OP_CODE
                                    && cnt <= tot - 6'd2);
      ext_write_strobe_pin_n_o <= !(state == ST_DATA && op == OP_XWR
                                    && cnt <= tot - 6'd2);
      ext_read_strobe_pin_n_o  <= !(state == ST_DATA && op == OP_XRD
                                    && cnt <= tot - 6'd2);
    end
  end

  // ---------------------------------------------------------------
  // wait pin: input while its function is enabled or latch bit 8 is one
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wait_capable_pin_o      <= 1'b0;
      wait_capable_pin_oe_n_o <= 1'b1;
    end else begin
      wait_capable_pin_o      <= 1'b0;
      wait_capable_pin_oe_n_o <= ctrl[CTL_WAIT] | latch[8];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  logic [5:0] chk_len;  // clocks spent in current access
  logic       chk_wait; // a wait stretch happened
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || state == ST_IDLE) begin
      chk_len  <= 6'd0;
      chk_wait <= 1'b0;
    end else begin
      chk_len  <= chk_len + 6'd1;
      chk_wait <= chk_wait | hold;
    end
  end

  sequence s_addr_mc;
    ale_o [*2] ##1 !ale_o [*2];
  endsequence

  a_ale_mc_width: assert property ($rose(ale_o) |-> s_addr_mc)
    else $error("ale not two high then two low clocks");
  a_ale_latch_addr: assert property (ale_o |->
      low_addr_data_port_oe_n_o == 8'h00)
    else $error("ale high while low port released");
  a_addr_on_low: assert property ($rose(ale_o) |->
      low_addr_data_port_o == acc_addr[7:0])
    else $error("low port lacks address at ale");
  a_high_driven: assert property (!ext_read_strobe_pin_n_o |->
      !high_address_port_oe_n_o)
    else $error("high port floats during read strobe");
  a_write_drives: assert property (!ext_write_strobe_pin_n_o |->
      low_addr_data_port_oe_n_o == 8'h00
      && low_addr_data_port_o == wdata)
    else $error("write data not driven");
  a_move_length: assert property ((state == ST_DATA && cnt == tot - 6'd1
      && !chk_wait) |-> chk_len + 6'd1 == tot)
    else $error("data move length wrong");
  a_iram_quiet: assert property (state == ST_IRAM |=> ##1
      ext_read_strobe_pin_n_o && ext_write_strobe_pin_n_o)
    else $error("strobe during on-chip ram access");
  a_high_goes_out: assert property ((cmd_go && cmd_op == OP_XRD
      && dp > XRAM_TOP) |=> state == ST_ADDR)
    else $error("high address not sent outside");
  a_ptr_dec: assert property ((cmd_go && cmd_op == OP_DEC) |=>
      dp == $past(dp) - 16'h0001)
    else $error("pointer not decremented");
  a_wait_hold: assert property ((state == ST_DATA && hold) |=>
      state == ST_DATA && cnt == $past(cnt))
    else $error("wait did not hold access");
endmodule : emb_top

/* testbench/emb_mem_model.sv */
// emb_mem_model: external byte ram and code rom on the muxed bus
// assumes: pins resolved here, the bench sets the wait length
`timescale 1ns/1ns
module emb_mem_model (
  input  wire logic       mclk_i,
  input  wire logic [7:0] lo_o_i,
  input  wire logic [7:0] lo_oe_n_i,
  input  wire logic [7:0] hi_i,
  input  wire logic       ale_i,
  input  wire logic       fetch_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       rd_n_i,
  input  wire logic [7:0] wait_len_i,
  output logic      [7:0] lo_pin_o,
  output logic            wait_n_o
);
  logic [7:0]  mem [0:65535];  // data space
  logic [15:0] adr;            // external address latch
  logic [7:0]  last  = 8'h00;  // last pin level
  logic [7:0]  drv;            // byte we return
  logic [7:0]  wcnt  = 8'h00;  // wait cycles left
  logic        wdone = 1'b0;   // one wait per strobe
  // ----------------------------------------
  // pin level: a released bus never keeps its old value
  // ----------------------------------------
  assign drv = !fetch_n_i ? (adr[7:0] ^ 8'h3c) : mem[adr];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!lo_oe_n_i[i])
        lo_pin_o[i] = lo_o_i[i];
      else if (!rd_n_i || !fetch_n_i)
        lo_pin_o[i] = drv[i];
      else
        lo_pin_o[i] = ~last[i];
    end
  end
  // latch, write and wait stretch
  always @(posedge mclk_i) begin
    last <= lo_pin_o;
    if (ale_i)
      adr <= {hi_i, lo_pin_o};
    if (!wr_n_i)
      mem[adr] <= lo_pin_o;
    if (rd_n_i && wr_n_i) begin
      wdone <= 1'b0;
      wcnt  <= 8'h00;
    end else if (!wdone) begin
      wdone <= 1'b1;
      wcnt  <= wait_len_i;
    end else if (wcnt != 8'h00)
      wcnt <= wcnt - 8'h01;
  end
  assign wait_n_o = (wcnt == 8'h00);
endmodule : emb_mem_model

/* testbench/tb_external_memory_bus_interface.sv */
// tb_external_memory_bus_interface: register level regression
// assumes: emb_mem_model on the pins, wishbone driven from here
`timescale 1ns/1ns
module tb_external_memory_bus_interface;
  import emb_pkg::*;
  logic        mclk_i    = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, ale, ps_n, wr_n, rd_n, hi_oe_n, wt_o, wt_oe_n, wt_n;
  logic [7:0]  lo_pin, lo_o, lo_oe_n, hi, wlen = 8'h00;
  int          fail_count = 0, tests_run = 0;
  int          n_ale = 0, n_rd = 0, n_wr = 0, n_ps = 0;
  int          b_ale, b_rd, b_wr, b_ps;
  logic [7:0]  ale_hi;   // high port seen under ale
  logic        ale_oe;   // both ports driven under ale
  always #20 mclk_i = ~mclk_i;
  emb_top uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .low_addr_data_port_i(lo_pin), .low_addr_data_port_o(lo_o),
    .low_addr_data_port_oe_n_o(lo_oe_n), .high_address_port_o(hi),
    .high_address_port_oe_n_o(hi_oe_n), .ale_o(ale), .program_fetch_strobe_n_o(ps_n),
    .ext_write_strobe_pin_n_o(wr_n), .ext_read_strobe_pin_n_o(rd_n),
    .wait_capable_pin_n_i(wt_n & (wt_oe_n | wt_o)), .wait_capable_pin_o(wt_o),
    .wait_capable_pin_oe_n_o(wt_oe_n));
  emb_mem_model ext (.mclk_i(mclk_i), .lo_o_i(lo_o), .lo_oe_n_i(lo_oe_n), .hi_i(hi),
    .ale_i(ale), .fetch_n_i(ps_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .wait_len_i(wlen),
    .lo_pin_o(lo_pin), .wait_n_o(wt_n));
  // ----------------------------------------
  // pin monitor: strobe cycle totals
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (ale === 1'b1) begin
      n_ale++;
      ale_hi = hi;
      ale_oe = (lo_oe_n === 8'h00) && (hi_oe_n === 1'b0);
    end
    if (rd_n === 1'b0) n_rd++;
    if (wr_n === 1'b0) n_wr++;
    if (ps_n === 1'b0) n_ps++;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t;
    t = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge mclk_i);
    while (ack !== 1'b1 && t < 50) begin
      @(posedge mclk_i);
      t++;
    end
    if (t >= 50) fail_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge mclk_i);
  endtask : wb
  // command, then poll busy; snapshot pin totals first
  task automatic op(input logic [7:0] code, input logic [7:0] b);
    int t;
    t = 0;
    b_ale = n_ale;
    b_rd = n_rd;
    b_wr = n_wr;
    b_ps = n_ps;
    wb(1'b1, OFF_CMD, {16'h0000, b, code});
    q = 32'h1;
    while (q[0] !== 1'b0 && t < 200) begin
      wb(1'b0, OFF_STAT, 32'h0);
      t++;
    end
    if (t >= 200) fail_count++;
  endtask : op
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    wb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl reset", q & 32'h3f, 32'h0);
    check("low port idle", {24'h0, lo_oe_n}, 32'hff);
    // decrement with a borrow across the byte boundary
    wb(1'b1, OFF_PTR0, 32'h0100);
    op(OP_DEC, 8'h00);
    wb(1'b0, OFF_PTR0, 32'h0);
    check("ptr0 dec", q & 32'hffff, 32'h00ff);
    wb(1'b1, OFF_P1LOW, 32'h00);
    wb(1'b1, OFF_P1HIGH, 32'h01);
    wb(1'b1, OFF_CTRL, 32'h20);
    op(OP_DEC, 8'h00);
    wb(1'b0, OFF_P1LOW, 32'h0);
    check("ptr1 low", q & 32'hff, 32'hff);
    wb(1'b0, OFF_P1HIGH, 32'h0);
    check("ptr1 high", q & 32'hff, 32'h00);
    wb(1'b0, OFF_PTR0, 32'h0);
    check("ptr0 kept", q & 32'hffff, 32'h00ff);
    // shortest and longest stretch, write then read back
    for (int s = 0; s < 8; s += 7) begin
      wb(1'b1, OFF_CTRL, s);
      wb(1'b1, OFF_PTR0, 32'h12c0 + s);
      op(OP_XWR, 8'ha5 ^ s[7:0]);
      check("write strobe", n_wr - b_wr, 4 * (s + 2) - 5);
      check("ale pulse", n_ale - b_ale, ALE_CLKS);
      check("high port", ale_hi, 8'h12);
      check("bus driven", ale_oe, 1);
      op(OP_XRD, 8'h00);
      check("read strobe", n_rd - b_rd, 4 * (s + 2) - 5);
      wb(1'b0, OFF_STAT, 32'h0);
      check("read byte", q[15:8], 8'ha5 ^ s[7:0]);
    end
    // on-chip ram off, on, and the first address above it
    wb(1'b1, OFF_CTRL, 32'h00);
    wb(1'b1, OFF_PTR0, 32'h03ff);
    op(OP_XWR, 8'h11);
    check("ram off goes out", n_ale - b_ale, ALE_CLKS);
    wb(1'b1, OFF_CTRL, 32'h08);
    op(OP_XWR, 8'h77);
    check("ram on stays in", n_ale - b_ale, 0);
    op(OP_XRD, 8'h00);
    wb(1'b0, OFF_STAT, 32'h0);
    check("ram byte", q[15:8], 8'h77);
    wb(1'b1, OFF_PTR0, 32'h0400);
    op(OP_XWR, 8'h22);
    check("above ram", n_ale - b_ale, ALE_CLKS);
    wb(1'b1, OFF_CTRL, 32'h00);
    wb(1'b1, OFF_PTR0, 32'h03ff);
    op(OP_XRD, 8'h00);
    wb(1'b0, OFF_STAT, 32'h0);
    check("outside byte", q[15:8], 8'h11);
    // code read, then a read held off by the wait pin
    wb(1'b1, OFF_PTR0, 32'h2345);
    op(OP_CODE, 8'h00);
    check("fetch strobe", n_ps - b_ps, 3);
    wb(1'b0, OFF_STAT, 32'h0);
    check("code byte", q[15:8], 8'h79);
    // wait latch low: pin driven low until its function is enabled
    wb(1'b1, OFF_LATCH, 32'h0ff);
    check("wait pin driven", wt_oe_n, 0);
    wlen <= 8'h06;
    // stretch 1: a synced wait answered after the strobe misses stretch 0
    wb(1'b1, OFF_CTRL, 32'h11);
    check("wait pin input", wt_oe_n, 1);
    wb(1'b1, OFF_PTR0, 32'h12c0);
    op(OP_XRD, 8'h00);
    check("wait stretches", n_rd - b_rd > 7, 1);
    wb(1'b0, OFF_STAT, 32'h0);
    check("waited byte", q[15:8], 8'ha5);
    end_sim();
  end
  // watchdog: whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    end_sim();
  end
endmodule : tb_external_memory_bus_interface
